// ===== hdl/lds_pkg.sv
// Constants shared by the LED driver status register bank.
package lds_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_HZ = 50_000_000;
  localparam int DIN_FILTER_NS = 10_000;
  localparam int DIN_FILTER_CYCLES = (DIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_MIN_NS = 200;
  localparam int OFF_MIN_CYCLES = (OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_MAX_NS = 20_000;
  localparam int OFF_MAX_CYCLES = OFF_MAX_NS / CLK_PERIOD_NS;
  localparam int PWM_FAIL_HZ = 100;
  localparam int PWM_FAIL_CYCLES = CLK_HZ / PWM_FAIL_HZ;
  localparam int FALLBACK_HZ = 200;
  localparam int FALLBACK_HALF_CYCLES = CLK_HZ / (2 * FALLBACK_HZ);
  localparam int WD_TIMEOUT_MS = 50;
  localparam int WD_TIMEOUT_CYCLES = WD_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int WD_PCT_Q1 = 24;
  localparam int WD_PCT_Q2 = 50;
  localparam int WD_PCT_Q3 = 74;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_SUPPLY_WD_OFFTIME = 6'h06;
  localparam logic [5:0] ADDR_LED_VOLTAGE_OFF = 6'h07;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_PWM_REF_CLOCK_FAULT = 18;
  localparam int BIT_SERIAL_SUPPLY_LOSS = 17;
  localparam int BIT_WD_PROGRESS_HI = 16;
  localparam int BIT_WD_PROGRESS_LO = 15;
  localparam int BIT_WATCHDOG_FAILURE = 14;
  localparam int BIT_BATTERY_UNDERVOLTAGE = 13;
  localparam int BIT_CH1_OFF_BELOW = 12;
  localparam int BIT_CH2_OFF_BELOW = 11;
  localparam int BIT_CH1_OFF_ABOVE = 10;
  localparam int BIT_CH2_OFF_ABOVE = 9;
  localparam int BIT_DIRECT_INPUT = 5;
  localparam int BIT_PARITY = 0;
  localparam int LSB_CH1_LED_VOLTAGE = 16;
  localparam int LSB_CH2_LED_VOLTAGE = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] RESET_FRAME = 24'h000001;
  localparam logic [7:0] RESET_LED_VOLTAGE = 8'h00;

endpackage

// ===== hdl/lds_pin_filter.sv
// Two-flop synchroniser with a persistence filter for one pin.
`timescale 1ns/1ps
module lds_pin_filter #(
  parameter int FILTER_CYCLES = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);

  localparam int CW = $clog2(FILTER_CYCLES + 1) + 1;

  logic sync_a;
  logic sync_b;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_level;

  if (FILTER_CYCLES < 1) begin : g_chk
    $error("lds_pin_filter: FILTER_CYCLES must be at least 1");
  end

  // The level changes only after the new value has stood for the full filter time.
  always_comb begin
    next_count = '0;
    next_level = level;
    if (sync_b != level) begin
      if (count >= CW'(FILTER_CYCLES - 1)) begin
        next_level = sync_b;
      end else begin
        next_count = count + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      count <= '0;
      level <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      count <= next_count;
      level <= next_level;
    end
  end

endmodule

// ===== hdl/lds_status_regs.sv
// Status register bank of a dual buck LED driver.
`timescale 1ns/1ps
// Contract
// - Bit 18 sets when the reference clock frequency is below the fault threshold.
// - While that fault flag is set, a fixed internal fallback clock replaces the reference clock.
// - The reference clock returns only after a read-and-clear while its frequency is good.
// - Bit 17 reads one while the serial supply is undervoltage, which enters limp home mode.
// - Bits 16 to 15 give watchdog elapsed time in quarters split at 24, 50 and 74 percent.
// - Bit 14 latches when the watchdog expires in active mode, and limp home mode follows.
// - Bits 12 and 11 read one while channel 1 or 2 off-time is below the minimum limit.
// - Bits 10 and 9 read one while channel 1 or 2 off-time is at or above the maximum limit.
// - Bit 5 is the direct input level after a fixed persistence filter.
// - Bit 0 of every frame is odd parity over the whole frame.
// - Bits 23 to 16 of the third register hold channel 1 LED voltage sampled while it is off.
// - Bits 15 to 8 of the third register hold channel 2 LED voltage sampled while it is off.
// - Under direct input or serial control a channel's result refreshes on every cycle it is off.
// - Under the PWM dimming generator a channel's result refreshes once, just before off ends.
// - Read-and-clear flags stay latched until cleared and stay set if their cause persists.
module lds_status_regs #(
  parameter int PWM_FAIL_CYCLES = lds_pkg::PWM_FAIL_CYCLES,
  parameter int FALLBACK_HALF_CYCLES = lds_pkg::FALLBACK_HALF_CYCLES,
  parameter int WD_TIMEOUT_CYCLES = lds_pkg::WD_TIMEOUT_CYCLES,
  parameter int DIN_FILTER_CYCLES = lds_pkg::DIN_FILTER_CYCLES,
  parameter int OFF_MIN_CYCLES = lds_pkg::OFF_MIN_CYCLES,
  parameter int OFF_MAX_CYCLES = lds_pkg::OFF_MAX_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic REG_REQ,
  input wire logic [5:0] REG_ADDR,
  input wire logic REG_CLEAR,
  output logic [23:0] REG_RDATA,
  output logic REG_ACK,
  input wire logic PWM_REFERENCE_CLOCK,
  output logic PWM_CLOCK_OUT,
  output logic FALLBACK_ACTIVE,
  input wire logic SERIAL_SUPPLY_UV,
  input wire logic BATTERY_UV,
  input wire logic DIRECT_INPUT,
  input wire logic ACTIVE_MODE,
  input wire logic WD_TRIGGER,
  output logic LIMP_HOME_MODE,
  input wire logic [1:0] CH_OFF,
  input wire logic [1:0] CH_PWM_DIMMING,
  input wire logic [1:0] CH_OFF_END_SOON,
  input wire logic [7:0] CH1_ADC,
  input wire logic [7:0] CH2_ADC
);

  localparam int PW = $clog2(PWM_FAIL_CYCLES + 1);
  localparam int FW = $clog2(FALLBACK_HALF_CYCLES + 1);
  localparam int WW = $clog2(WD_TIMEOUT_CYCLES + 1);
  localparam int OW = $clog2(OFF_MAX_CYCLES + 1);

  if (PWM_FAIL_CYCLES < 4 || FALLBACK_HALF_CYCLES < 1 || WD_TIMEOUT_CYCLES < 4 ||
      OFF_MIN_CYCLES < 1 || OFF_MAX_CYCLES <= OFF_MIN_CYCLES) begin : g_chk
    $error("lds_status_regs: timing parameters out of range");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] with_parity(input logic [23:0] frame);
    logic [23:0] f;
    f = frame;
    f[lds_pkg::BIT_PARITY] = ~(^frame[23:1]);
    return f;
  endfunction

  function automatic logic [1:0] wd_quarter(input logic [WW-1:0] cnt);
    logic [63:0] scaled;
    logic [1:0] q;
    scaled = 64'(cnt) * 64'd100;
    q = 2'h0;
    if (scaled >= 64'(lds_pkg::WD_PCT_Q3) * 64'(WD_TIMEOUT_CYCLES)) begin
      q = 2'h3;
    end else if (scaled >= 64'(lds_pkg::WD_PCT_Q2) * 64'(WD_TIMEOUT_CYCLES)) begin
      q = 2'h2;
    end else if (scaled >= 64'(lds_pkg::WD_PCT_Q1) * 64'(WD_TIMEOUT_CYCLES)) begin
      q = 2'h1;
    end
    return q;
  endfunction

  // ----------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------
  logic ref_clk_s;
  logic supply_loss_s;
  logic battery_uv_s;
  logic direct_input_filtered;

  lds_pin_filter #(.FILTER_CYCLES(1)) u_ref_clk (
    .clk(CLK_SYS), .rst(RST), .pin(PWM_REFERENCE_CLOCK), .level(ref_clk_s));
  lds_pin_filter #(.FILTER_CYCLES(1)) u_supply (
    .clk(CLK_SYS), .rst(RST), .pin(SERIAL_SUPPLY_UV), .level(supply_loss_s));
  lds_pin_filter #(.FILTER_CYCLES(1)) u_battery (
    .clk(CLK_SYS), .rst(RST), .pin(BATTERY_UV), .level(battery_uv_s));
  lds_pin_filter #(.FILTER_CYCLES(DIN_FILTER_CYCLES)) u_din (
    .clk(CLK_SYS), .rst(RST), .pin(DIRECT_INPUT), .level(direct_input_filtered));

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic ref_clk_d, next_ref_clk_d;
  logic [PW-1:0] period_cnt, next_period_cnt;
  logic freq_ok, next_freq_ok;
  logic pwm_ref_clock_fault, next_pwm_ref_clock_fault;
  logic [FW-1:0] fb_cnt, next_fb_cnt;
  logic fb_clk, next_fb_clk;
  logic [WW-1:0] wd_cnt, next_wd_cnt;
  logic watchdog_failure, next_watchdog_failure;
  logic [1:0] watchdog_progress;
  logic [1:0] off_d, next_off_d;
  logic [OW-1:0] off_cnt [2];
  logic [OW-1:0] next_off_cnt [2];
  logic [1:0] off_below, next_off_below;
  logic [1:0] off_above, next_off_above;
  logic [7:0] led_v [2];
  logic [7:0] next_led_v [2];
  logic [7:0] adc [2];
  logic [23:0] frame_sr2;
  logic [23:0] frame_sr3;
  logic [23:0] next_rdata;
  logic next_ack;
  logic clr_sr2;
  logic clr_sr3;

  assign adc[0] = CH1_ADC;
  assign adc[1] = CH2_ADC;
  assign clr_sr2 = REG_REQ && REG_CLEAR && (REG_ADDR == lds_pkg::ADDR_SUPPLY_WD_OFFTIME);
  assign clr_sr3 = REG_REQ && REG_CLEAR && (REG_ADDR == lds_pkg::ADDR_LED_VOLTAGE_OFF);
  assign watchdog_progress = wd_quarter(wd_cnt);

  // ----------------------------------------------------------------
  // Reference clock supervision, fallback clock and watchdog
  // ----------------------------------------------------------------
  always_comb begin
    next_ref_clk_d = ref_clk_s;
    next_period_cnt = period_cnt;
    next_freq_ok = freq_ok;
    if (ref_clk_s && !ref_clk_d) begin
      next_period_cnt = '0;
      next_freq_ok = 1'b1;
    end else if (period_cnt >= PW'(PWM_FAIL_CYCLES)) begin
      next_freq_ok = 1'b0;
    end else begin
      next_period_cnt = period_cnt + PW'(1);
    end
    // Setting wins over a clear issued in the same cycle.
    next_pwm_ref_clock_fault = pwm_ref_clock_fault;
    if (clr_sr2 && freq_ok) begin
      next_pwm_ref_clock_fault = 1'b0;
    end
    if (!freq_ok) begin
      next_pwm_ref_clock_fault = 1'b1;
    end
    next_fb_cnt = fb_cnt + FW'(1);
    next_fb_clk = fb_clk;
    if (fb_cnt >= FW'(FALLBACK_HALF_CYCLES - 1)) begin
      next_fb_cnt = '0;
      next_fb_clk = !fb_clk;
    end
    next_wd_cnt = wd_cnt;
    next_watchdog_failure = watchdog_failure;
    if (clr_sr2) begin
      next_watchdog_failure = 1'b0;
    end
    if (!ACTIVE_MODE || WD_TRIGGER) begin
      next_wd_cnt = '0;
    end else if (wd_cnt >= WW'(WD_TIMEOUT_CYCLES - 1)) begin
      next_wd_cnt = '0;
      next_watchdog_failure = 1'b1;
    end else begin
      next_wd_cnt = wd_cnt + WW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Off-time supervision and LED voltage capture
  // ----------------------------------------------------------------
  always_comb begin
    next_off_d = CH_OFF;
    next_off_below = off_below;
    next_off_above = off_above;
    for (int i = 0; i < 2; i++) begin
      next_off_cnt[i] = off_cnt[i];
      next_led_v[i] = led_v[i];
      if (CH_OFF[i]) begin
        if (!off_d[i]) begin
          next_off_cnt[i] = OW'(1);
        end else if (off_cnt[i] < OW'(OFF_MAX_CYCLES)) begin
          next_off_cnt[i] = off_cnt[i] + OW'(1);
        end
        next_off_above[i] = (next_off_cnt[i] >= OW'(OFF_MAX_CYCLES));
      end else if (off_d[i]) begin
        next_off_below[i] = (off_cnt[i] < OW'(OFF_MIN_CYCLES));
        next_off_above[i] = (off_cnt[i] >= OW'(OFF_MAX_CYCLES));
      end
      if (clr_sr3) begin
        next_led_v[i] = lds_pkg::RESET_LED_VOLTAGE;
      end
      if (CH_OFF[i] && !CH_PWM_DIMMING[i]) begin
        next_led_v[i] = adc[i];
      end else if (CH_OFF[i] && CH_OFF_END_SOON[i]) begin
        next_led_v[i] = adc[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Frames and read port
  // ----------------------------------------------------------------
  always_comb begin
    frame_sr2 = '0;
    frame_sr2[lds_pkg::BIT_PWM_REF_CLOCK_FAULT] = pwm_ref_clock_fault;
    frame_sr2[lds_pkg::BIT_SERIAL_SUPPLY_LOSS] = supply_loss_s;
    frame_sr2[lds_pkg::BIT_WD_PROGRESS_HI:lds_pkg::BIT_WD_PROGRESS_LO] = watchdog_progress;
    frame_sr2[lds_pkg::BIT_WATCHDOG_FAILURE] = watchdog_failure;
    frame_sr2[lds_pkg::BIT_BATTERY_UNDERVOLTAGE] = battery_uv_s;
    frame_sr2[lds_pkg::BIT_CH1_OFF_BELOW] = off_below[0];
    frame_sr2[lds_pkg::BIT_CH2_OFF_BELOW] = off_below[1];
    frame_sr2[lds_pkg::BIT_CH1_OFF_ABOVE] = off_above[0];
    frame_sr2[lds_pkg::BIT_CH2_OFF_ABOVE] = off_above[1];
    frame_sr2[lds_pkg::BIT_DIRECT_INPUT] = direct_input_filtered;
    frame_sr3 = '0;
    frame_sr3[lds_pkg::LSB_CH1_LED_VOLTAGE +: 8] = led_v[0];
    frame_sr3[lds_pkg::LSB_CH2_LED_VOLTAGE +: 8] = led_v[1];
    next_ack = REG_REQ;
    next_rdata = REG_RDATA;
    if (REG_REQ) begin
      unique case (REG_ADDR)
        lds_pkg::ADDR_SUPPLY_WD_OFFTIME: next_rdata = with_parity(frame_sr2);
        lds_pkg::ADDR_LED_VOLTAGE_OFF: next_rdata = with_parity(frame_sr3);
        default: next_rdata = with_parity(24'h000000);
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ref_clk_d <= 1'b0;
      period_cnt <= '0;
      freq_ok <= 1'b1;
      pwm_ref_clock_fault <= 1'b0;
      fb_cnt <= '0;
      fb_clk <= 1'b0;
      wd_cnt <= '0;
      watchdog_failure <= 1'b0;
      off_d <= 2'h0;
      off_below <= 2'h0;
      off_above <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        off_cnt[i] <= '0;
        led_v[i] <= lds_pkg::RESET_LED_VOLTAGE;
      end
      REG_RDATA <= lds_pkg::RESET_FRAME;
      REG_ACK <= 1'b0;
      PWM_CLOCK_OUT <= 1'b0;
      FALLBACK_ACTIVE <= 1'b0;
      LIMP_HOME_MODE <= 1'b0;
    end else begin
      ref_clk_d <= next_ref_clk_d;
      period_cnt <= next_period_cnt;
      freq_ok <= next_freq_ok;
      pwm_ref_clock_fault <= next_pwm_ref_clock_fault;
      fb_cnt <= next_fb_cnt;
      fb_clk <= next_fb_clk;
      wd_cnt <= next_wd_cnt;
      watchdog_failure <= next_watchdog_failure;
      off_d <= next_off_d;
      off_below <= next_off_below;
      off_above <= next_off_above;
      for (int i = 0; i < 2; i++) begin
        off_cnt[i] <= next_off_cnt[i];
        led_v[i] <= next_led_v[i];
      end
      REG_RDATA <= next_rdata;
      REG_ACK <= next_ack;
      PWM_CLOCK_OUT <= pwm_ref_clock_fault ? fb_clk : ref_clk_s;
      FALLBACK_ACTIVE <= pwm_ref_clock_fault;
      LIMP_HOME_MODE <= watchdog_failure || supply_loss_s;
    end
  end

endmodule

// ===== bench/lds_status_regs_assertions.sv
// Port checker for the status register bank.
`timescale 1ns/1ps
module lds_status_regs_chk (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic REG_REQ,
  input wire logic [5:0] REG_ADDR,
  input wire logic [23:0] REG_RDATA,
  input wire logic REG_ACK,
  input wire logic FALLBACK_ACTIVE,
  input wire logic SERIAL_SUPPLY_UV,
  input wire logic LIMP_HOME_MODE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_ack_follows_req: assert property (REG_REQ |=> REG_ACK)
    else $error("answer missing one cycle after a request");
  a_ack_has_cause: assert property (REG_ACK |-> $past(REG_REQ))
    else $error("answer without a request");
  a_parity_odd: assert property (REG_ACK |-> ^REG_RDATA)
    else $error("frame parity is not odd");
  a_sr2_reserved_zero: assert property (REG_ACK && $past(REG_ADDR) == 6'h06 |->
    REG_RDATA[23:19] == 5'h00 && REG_RDATA[8:6] == 3'h0 && REG_RDATA[4:1] == 4'h0)
    else $error("reserved supply status bits not zero");
  a_sr3_unused_zero: assert property (REG_ACK && $past(REG_ADDR) == 6'h07 |->
    REG_RDATA[7:1] == 7'h00)
    else $error("unused voltage status bits not zero");
  a_unmapped_empty: assert property (REG_ACK && !($past(REG_ADDR) inside {6'h06, 6'h07})
    |-> REG_RDATA == 24'h000001)
    else $error("unmapped address returned data");
  a_fault_fallback_on: assert property (REG_ACK && $past(REG_ADDR) == 6'h06 &&
    REG_RDATA[18] |-> FALLBACK_ACTIVE)
    else $error("clock fault flagged without fallback");
  a_wd_limp_home: assert property (REG_ACK && $past(REG_ADDR) == 6'h06 &&
    REG_RDATA[14] |-> LIMP_HOME_MODE)
    else $error("watchdog failure without limp home");
  a_supply_limp_home: assert property (SERIAL_SUPPLY_UV [*4] |=> LIMP_HOME_MODE)
    else $error("supply loss without limp home");
  c_fault_read: cover property (REG_ACK && REG_RDATA[18]);
  c_watchdog_failure_read: cover property (REG_ACK && REG_RDATA[14]);
  c_limp_home: cover property (LIMP_HOME_MODE);
  c_fallback: cover property ($fell(FALLBACK_ACTIVE));
endmodule

bind lds_status_regs lds_status_regs_chk chk (.CLK_SYS(CLK_SYS), .RST(RST),
  .REG_REQ(REG_REQ), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
  .FALLBACK_ACTIVE(FALLBACK_ACTIVE), .SERIAL_SUPPLY_UV(SERIAL_SUPPLY_UV),
  .LIMP_HOME_MODE(LIMP_HOME_MODE));

// ===== bench/lds_host_model.sv
// Host side of the status read port, one read request at a time.
`timescale 1ns/1ps
module lds_host_model (
  input wire logic clk,
  output logic req,
  output logic [5:0] addr,
  output logic clr,
  input wire logic ack,
  input wire logic [23:0] rdata
);
  logic [23:0] last;
  initial begin
    req = 1'b0;
    addr = 6'h00;
    clr = 1'b0;
  end
  // Released address lines show the inverse so stale values are never reused.
  task automatic read(input logic [5:0] a, input logic c);
    @(posedge clk);
    #1;
    req = 1'b1;
    addr = a;
    clr = c;
    @(posedge clk);
    #1;
    req = 1'b0;
    addr = ~a;
    clr = 1'b0;
    if (ack === 1'b1) last = rdata;
  endtask
endmodule

// ===== bench/test_lds_status_regs.sv
// Self-checking bench for the status register bank.
`timescale 1ns/1ps
module test_lds_status_regs;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic REG_REQ, REG_CLEAR, REG_ACK, PWM_CLOCK_OUT, FALLBACK_ACTIVE, LIMP_HOME_MODE;
  logic [5:0] REG_ADDR;
  logic [23:0] REG_RDATA;
  logic PWM_REFERENCE_CLOCK = 1'b0, pwm_run = 1'b1;
  logic SERIAL_SUPPLY_UV = 1'b0, BATTERY_UV = 1'b0, DIRECT_INPUT = 1'b0;
  logic ACTIVE_MODE = 1'b0, WD_TRIGGER = 1'b0;
  logic [1:0] CH_OFF = 2'b00, CH_PWM_DIMMING = 2'b00, CH_OFF_END_SOON = 2'b00;
  logic [7:0] CH1_ADC = 8'h00, CH2_ADC = 8'h00, a1, a2;
  logic [23:0] exp_q[$];
  logic [23:0] st = 24'h000000;
  int fails = 0, n_tests = 0, cnt;
  int wq[4] = '{10, 37, 62, 88};
  always #10 CLK_SYS = ~CLK_SYS;
  lds_status_regs #(.PWM_FAIL_CYCLES(20), .FALLBACK_HALF_CYCLES(3), .WD_TIMEOUT_CYCLES(100),
    .DIN_FILTER_CYCLES(4), .OFF_MAX_CYCLES(40)) dut (.CLK_SYS(CLK_SYS),
    .RST(RST), .REG_REQ(REG_REQ), .REG_ADDR(REG_ADDR), .REG_CLEAR(REG_CLEAR),
    .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .PWM_REFERENCE_CLOCK(PWM_REFERENCE_CLOCK),
    .PWM_CLOCK_OUT(PWM_CLOCK_OUT), .FALLBACK_ACTIVE(FALLBACK_ACTIVE),
    .SERIAL_SUPPLY_UV(SERIAL_SUPPLY_UV), .BATTERY_UV(BATTERY_UV), .DIRECT_INPUT(DIRECT_INPUT),
    .ACTIVE_MODE(ACTIVE_MODE), .WD_TRIGGER(WD_TRIGGER), .LIMP_HOME_MODE(LIMP_HOME_MODE),
    .CH_OFF(CH_OFF), .CH_PWM_DIMMING(CH_PWM_DIMMING), .CH_OFF_END_SOON(CH_OFF_END_SOON),
    .CH1_ADC(CH1_ADC), .CH2_ADC(CH2_ADC));
  lds_host_model host (.clk(CLK_SYS), .req(REG_REQ), .addr(REG_ADDR), .clr(REG_CLEAR),
    .ack(REG_ACK), .rdata(REG_RDATA));
  // ----
  // Helpers
  // ----
  function automatic logic [23:0] fr(input logic [23:0] d);
    return {d[23:1], ~^d[23:1]};
  endfunction
  task automatic chk_frame(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_frame({23'h0, got}, {23'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic c, input logic [23:0] d);
    exp_q.push_back(fr(d));
    host.read(a, c);
  endtask
  task automatic kick();
    WD_TRIGGER = 1'b1;
    cyc(1);
    WD_TRIGGER = 1'b0;
  endtask
  task automatic print_verdict();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----
  // Stimulus, monitor and watchdog
  // ----
  always begin
    repeat (3) @(posedge CLK_SYS);
    #1;
    if (pwm_run) PWM_REFERENCE_CLOCK = ~PWM_REFERENCE_CLOCK;
  end
  always @(posedge CLK_SYS) begin
    if (REG_ACK === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("mismatch t=%0t got=%h exp=none", $time, REG_RDATA);
      end else begin
        chk_frame(REG_RDATA, exp_q.pop_front());
      end
    end
  end
  initial begin
    #400_000;
    fails++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h65365a6f));
    cyc(16);
    RST = 1'b0;
    rd(6'h06, 1'b0, 24'h000000);
    rd(6'h07, 1'b1, 24'h000000);
    for (int i = 0; i < 4; i++) rd(6'h08 + 6'($urandom_range(0, 55)), 1'b1, 24'h0);
    SERIAL_SUPPLY_UV = 1'b1;
    BATTERY_UV = 1'b1;
    DIRECT_INPUT = 1'b1;
    cyc(12);
    rd(6'h06, 1'b0, 24'h022020);
    chk_bit(LIMP_HOME_MODE, 1'b1);
    SERIAL_SUPPLY_UV = 1'b0;
    BATTERY_UV = 1'b0;
    DIRECT_INPUT = 1'b0;
    cyc(12);
    rd(6'h06, 1'b1, 24'h000000);
    chk_bit(LIMP_HOME_MODE, 1'b0);
    pwm_run = 1'b0;
    cyc(40);
    rd(6'h06, 1'b1, 24'h040000);
    rd(6'h06, 1'b0, 24'h040000);
    chk_bit(FALLBACK_ACTIVE, 1'b1);
    cnt = 0;
    repeat (20) begin
      a1[0] = PWM_CLOCK_OUT;
      cyc(1);
      if (PWM_CLOCK_OUT !== a1[0]) cnt++;
    end
    chk_bit(cnt >= 4, 1'b1);
    pwm_run = 1'b1;
    cyc(15);
    rd(6'h06, 1'b1, 24'h040000);
    rd(6'h06, 1'b0, 24'h000000);
    cyc(2);
    chk_bit(FALLBACK_ACTIVE, 1'b0);
    a1 = 8'($urandom);
    a2 = 8'($urandom);
    CH1_ADC = a1;
    CH2_ADC = a2;
    CH_OFF = 2'b11;
    cyc(3);
    CH_OFF = 2'b10;
    cyc(50);
    st = 24'h001200;
    rd(6'h06, 1'b0, st);
    CH_PWM_DIMMING = 2'b10;
    cyc(1);
    rd(6'h07, 1'b1, {a1, a2, 8'h00});
    rd(6'h07, 1'b0, 24'h000000);
    CH1_ADC = ~a1;
    a2 = 8'($urandom);
    CH2_ADC = a2;
    CH_OFF_END_SOON = 2'b10;
    cyc(1);
    CH_OFF_END_SOON = 2'b00;
    CH2_ADC = ~a2;
    cyc(2);
    rd(6'h07, 1'b0, {8'h00, a2, 8'h00});
    CH_OFF = 2'b00;
    CH_PWM_DIMMING = 2'b00;
    ACTIVE_MODE = 1'b1;
    for (int i = 0; i < 4; i++) begin
      kick();
      cyc(wq[i]);
      rd(6'h06, 1'b0, st | {7'h00, 2'(i), 15'h0000});
    end
    kick();
    cyc(110);
    chk_bit(LIMP_HOME_MODE, 1'b1);
    rd(6'h06, 1'b1, st | 24'h004000);
    kick();
    rd(6'h06, 1'b0, st);
    chk_frame(host.last, fr(st));
    cyc(2);
    chk_bit(LIMP_HOME_MODE, 1'b0);
    cyc(2);
    print_verdict();
  end
endmodule
